// [rtl/pci_lock_target.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pci_lock_params.svh"

//
// Contract
// [R1] Initiator gets grant while lock free
// [R2] Lock request: read, lock asserted after address
// [R3] Lock set by first completed data transfer
// [R4] Owner holds lock until done or abort
// [R5] Locked target freed by frame, lock idle
// [R6] Retried first transaction releases lock
// [R7] Owner continues with lock low at address
// [R8] Locked target claims owner's continuing transaction
// [R9] Owner releases lock with irdy idle
// [R10] Lock seen at address: locked target retries
// [R11] Never initiates lock; excludes others when locked
// [R12] Core side locks only 32-byte line
// [R13] Drain earlier write snoops, then snoop read
// [R14] Core hits on locked line are retried
// [R15] Most recent line stays locked to core
// [R16] Snoop disable makes lock ignored
// [R17] Even parity over AD, command, PAR
// [R18] Driver sends PAR one clock later
// [R19] Unused lanes stable, counted in parity
// [R20] Parity error sets status; response gated
// [R21] PERR data errors; SERR address, special
// [R22] Strap picks host or agent mode
// [R23] Agent mode ignores memory until translation
// [R24] Only locked target excluded, others proceed
// [R25] Lock flag and line kept, then cleared
module pci_lock_target
  import pci_lock_pkg::*;
(
  input  wire logic        clk_in,              // 100 MHz clock
  input  wire logic        sys_rst_in,          // Sync reset, high
  input  wire logic        pci_clk_in,          // Bus clock pin
  input  wire logic        frame_n_in,          // Frame pin, low
  input  wire logic        irdy_n_in,           // Initiator ready
  input  wire logic        trdy_n_in,           // Target ready
  input  wire logic        lock_n_in,           // Lock pin, low
  input  wire logic        par_in,              // Parity pin
  input  wire logic [3:0]  cbe_n_in,            // Command/enables
  input  wire logic [31:0] ad_in,               // Address/data pins
  input  wire logic        host_agent_select_strap_in, // High: host
  input  wire logic        addr_map_b_strap_in, // High: map B
  input  wire logic        mem_space_en_in,     // Memory target on
  input  wire logic        inbound_xlate_en_in, // Inbound window on
  input  wire logic        snoop_disable_in,    // No-snoop config
  input  wire logic        parity_resp_en_in,   // Parity response
  input  wire logic        dpe_clear_in,        // Clear status bit
  input  wire logic [31:0] mem_base_in,         // Local window base
  input  wire logic [31:0] mem_mask_in,         // Local window mask
  input  wire logic        wr_snoop_pending_in, // Older writes open
  input  wire logic        snoop_ack_in,        // Lock snoop done
  input  wire logic        core_req_in,         // Core access valid
  input  wire logic [31:0] core_addr_in,        // Core address
  input  wire logic [31:0] rd_data_in,          // Read data driven
  input  wire logic        rd_data_oe_in,       // Read data driven
  output logic             claim_out,           // Transaction ours
  output logic             retry_out,           // Retry this one
  output logic             hold_trdy_out,       // Stall data phase
  output logic             snoop_req_out,       // Lock snoop request
  output logic      [31:0] snoop_addr_out,      // Lock snoop address
  output logic             locked_out,          // Target is locked
  output line_t            lock_line_out,       // Locked line
  output logic             core_retry_out,      // Retry core access
  output logic             par_out,             // Generated parity
  output logic             par_oe_out,          // Parity enable
  output logic             perr_n_out,          // Parity error, low
  output logic             perr_oe_out,         // Its enable
  output logic             serr_n_out,          // System error, low
  output logic             serr_oe_out,         // Its enable
  output logic             dpe_status_out,      // Sticky parity error
  output logic             host_mode_out,       // Host bridge mode
  output logic             config_error_out     // Agent with map A
);

  // Command classes
  function automatic logic rd_cmd(input logic [3:0] c);
    rd_cmd = (c == `CMD_MEM_RD) | (c == `CMD_MEM_RD_MULT)
           | (c == `CMD_MEM_RD_LINE);
  endfunction

  function automatic logic mem_cmd(input logic [3:0] c);
    mem_cmd = rd_cmd(c) | (c == `CMD_MEM_WR) | (c == `CMD_MEM_WR_INV);
  endfunction

  // Same 32-byte line
  function automatic logic line_match(input logic [31:0] a,
                                      input line_t l);
    line_match = (a[31:`LINE_LSB] == l);
  endfunction

  logic [`SYNC_W-1:0] raw;
  logic [`SYNC_W-1:0] syn;
  logic               pclk_q;
  logic               frame_q;
  logic               ap_q;
  logic               dx_q;
  logic               rd_q;
  logic               special_q;
  logic [31:0]        cur_addr;
  lock_state_e        state;
  lock_state_e        next_state;

  pci_sample_if u_bus ();

  // Every pin crosses two flops before use
  assign raw = {pci_clk_in, frame_n_in, irdy_n_in, trdy_n_in,
                lock_n_in, par_in, cbe_n_in, ad_in,
                host_agent_select_strap_in, addr_map_b_strap_in};

  pin_sync #(
    .W (`SYNC_W)
  ) u_sync (
    .clk_in (clk_in),
    .d_in   (raw),
    .q_out  (syn)
  );

  // Unpacked, active-high view of the sampled bus
  wire        pclk       = syn[43];
  wire        frame      = ~syn[42];
  wire        irdy       = ~syn[41];
  wire        trdy       = ~syn[40];
  wire        lock       = ~syn[39];
  wire        par_s      = syn[38];
  wire [3:0]  cbe        = syn[37:34];
  wire [31:0] ad         = syn[33:2];
  wire        strap_host = syn[1];
  wire        strap_mapb = syn[0];

  // Bus clock edges, eight system clocks apart at 80 ns
  wire pedge = pclk & ~pclk_q;
  wire addr_phase = pedge & frame & ~frame_q;
  wire xfer = pedge & irdy & trdy;
  wire end_txn = pedge & ~frame & ~irdy;

  // Target decode, lock ignored unless we are locked
  wire hit = ((ad ^ mem_base_in) & mem_mask_in) == 32'h0000_0000;
  wire tgt_on = mem_space_en_in
              & (host_mode_out | inbound_xlate_en_in);  // [R23]
  wire want = addr_phase & mem_cmd(cbe) & hit & tgt_on;
  wire held = (state == LK_HELD);
  wire refuse = want & held & lock;                     // [R10] [R11]
  wire accept = want & ~refuse;                         // [R8] [R24]
  wire ours_xfer = xfer & claim_out & ~retry_out;

  // Lock attempt: read claimed with lock low at address
  wire lock_try = accept & rd_cmd(cbe) & ~lock
                & ~snoop_disable_in;                    // [R2] [R16]

  // Bus clock edge and previous frame level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pclk_q  <= 1'b0;
      frame_q <= 1'b0;
    end else begin
      pclk_q  <= pclk;
      frame_q <= pedge ? frame : frame_q;
    end
  end

  // Claim and retry stand for the whole transaction
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      claim_out <= 1'b0;
      retry_out <= 1'b0;
      rd_q      <= 1'b0;
      special_q <= 1'b0;
    end else if (addr_phase) begin
      claim_out <= accept;
      retry_out <= refuse;                              // [R10]
      rd_q      <= rd_cmd(cbe);
      special_q <= (cbe == `CMD_SPECIAL);
    end else if (end_txn) begin
      claim_out <= 1'b0;
      retry_out <= 1'b0;
    end
  end

  // Running address; one word per completed data phase
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cur_addr <= `RST_ADDR;
    end else if (addr_phase) begin
      cur_addr <= ad;
    end else if (ours_xfer) begin
      cur_addr <= cur_addr + `ADDR_STEP;
    end
  end

  // Remember what the ended bus clock carried for parity
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ap_q <= 1'b0;
      dx_q <= 1'b0;
    end else if (pedge) begin
      ap_q <= addr_phase;
      dx_q <= xfer & ((claim_out & ~retry_out & ~rd_q) | special_q);
    end
  end

  // Lock tracking; never entered from our own initiator
  always_comb begin
    next_state = state;
    unique case (state)
      LK_FREE: begin
        if (lock_try) begin
          next_state = LK_REQ;
        end
      end
      LK_REQ: begin
        // Lock must show on the clock after the address
        if (pedge) begin
          next_state = lock ? LK_DRAIN : LK_FREE;       // [R2] [R1]
        end
      end
      LK_DRAIN: begin
        if (end_txn) begin
          next_state = LK_FREE;
        end else if (~wr_snoop_pending_in) begin
          next_state = LK_SNOOP;                        // [R13]
        end
      end
      LK_SNOOP: begin
        // Snoop runs to completion even if the bus gives up
        if (snoop_ack_in) begin
          next_state = LK_FIRST;                        // [R13]
        end
      end
      LK_FIRST: begin
        if (ours_xfer) begin
          next_state = LK_HELD;                         // [R3] [R25]
        end else if (end_txn | (pedge & ~lock)) begin
          next_state = LK_FREE;                         // [R6] [R4]
        end
      end
      LK_HELD: begin
        if (pedge & ~frame & ~lock) begin
          next_state = LK_FREE;                         // [R5] [R9]
        end
      end
      default: begin
        next_state = LK_FREE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= LK_FREE;
    end else begin
      state <= next_state;
    end
  end

  // Snoop handshake and data-phase stall while it runs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      snoop_req_out  <= 1'b0;
      snoop_addr_out <= `RST_ADDR;
      hold_trdy_out  <= 1'b0;
    end else begin
      snoop_req_out  <= (next_state == LK_SNOOP);       // [R13]
      hold_trdy_out  <= (next_state == LK_DRAIN)
                      | (next_state == LK_SNOOP)
                      | (state == LK_REQ);
      if (state == LK_REQ) begin
        snoop_addr_out <= cur_addr;
      end
    end
  end

  // Lock flag and locked line; line follows latest access
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      locked_out    <= 1'b0;
      lock_line_out <= `RST_LINE;
    end else begin
      locked_out <= (next_state == LK_HELD);            // [R25]
      if (next_state == LK_FREE) begin
        lock_line_out <= `RST_LINE;                     // [R25]
      end else if (ours_xfer & ((state == LK_FIRST) | held)) begin
        lock_line_out <= cur_addr[31:`LINE_LSB];        // [R15] [R25]
      end
    end
  end

  // Core: only the locked line is fenced off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      core_retry_out <= 1'b0;
    end else begin
      core_retry_out <= core_req_in & held
                      & line_match(core_addr_in, lock_line_out); // [R12] [R14]
    end
  end

  // Parity checker inputs
  assign u_bus.pedge    = pedge;
  assign u_bus.ad       = ad;
  assign u_bus.cbe      = cbe;
  assign u_bus.par      = par_s;
  assign u_bus.chk_addr = pedge & ap_q;
  assign u_bus.chk_data = pedge & dx_q;
  assign u_bus.special  = special_q;
  assign u_bus.resp_en  = parity_resp_en_in;            // [R20]
  assign u_bus.drv_oe   = rd_data_oe_in;
  assign u_bus.drv_ad   = rd_data_in;

  pci_parity_unit u_par (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .bus         (u_bus.chk),
    .par_out     (par_out),
    .par_oe_out  (par_oe_out),
    .perr_n_out  (perr_n_out),
    .perr_oe_out (perr_oe_out),
    .serr_n_out  (serr_n_out),
    .serr_oe_out (serr_oe_out)
  );

  // Sticky detected-parity-error; a new error beats the clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dpe_status_out <= 1'b0;
    end else begin
      dpe_status_out <= (dpe_status_out & ~dpe_clear_in)
                      | u_bus.addr_err | u_bus.data_err; // [R20]
    end
  end

  // Straps follow the pins through reset, frozen at release
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      host_mode_out    <= strap_host;                   // [R22]
      config_error_out <= ~strap_host & ~strap_mapb;    // [R22]
    end
  end

endmodule // pci_lock_target

`default_nettype wire

// [rtl/pci_parity_unit.sv]
`timescale 1ns/1ps
`default_nettype none

module pci_parity_unit (
  input  wire logic     clk_in,      // System clock
  input  wire logic     sys_rst_in,  // Sync reset, high
  pci_sample_if.chk     bus,         // Sampled bus view
  output logic          par_out,     // Generated parity
  output logic          par_oe_out,  // Parity pin enable
  output logic          perr_n_out,  // Parity error, low
  output logic          perr_oe_out, // Parity error enable
  output logic          serr_n_out,  // System error, low
  output logic          serr_oe_out  // System error enable
);

  // PAR trails the phase it covers by one bus clock
  logic prev_par;
  wire bus_bad  = prev_par ^ bus.par;                   // [R17] [R19]
  wire addr_bad = bus.chk_addr & bus_bad;
  wire data_bad = bus.chk_data & bus_bad;
  wire next_perr = bus.resp_en & data_bad & ~bus.special;       // [R21]
  wire next_serr = bus.resp_en
                 & (addr_bad | (data_bad & bus.special));       // [R21]

  // Error pulses always reach status; pins only when enabled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus.addr_err <= 1'b0;
      bus.data_err <= 1'b0;
    end else begin
      bus.addr_err <= addr_bad; // [R20]
      bus.data_err <= data_bad; // [R20]
    end
  end

  // Parity driven one bus clock after the data it covers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      par_out    <= 1'b0;
      par_oe_out <= 1'b0;
      prev_par   <= 1'b0;
    end else if (bus.pedge) begin
      prev_par   <= ^{bus.ad, bus.cbe};     // [R18]
      par_out    <= ^{bus.drv_ad, bus.cbe}; // [R18] [R17]
      par_oe_out <= bus.drv_oe;             // [R18]
    end
  end

  // Error pins held for one whole bus clock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      perr_n_out  <= 1'b1;
      perr_oe_out <= 1'b0;
      serr_n_out  <= 1'b1;
      serr_oe_out <= 1'b0;
    end else if (bus.pedge) begin
      perr_n_out  <= ~next_perr;
      perr_oe_out <= next_perr;
      serr_n_out  <= ~next_serr;
      serr_oe_out <= next_serr;
    end
  end

endmodule // pci_parity_unit

`default_nettype wire

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; stage one feeds stage two only
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,  // Sampling clock
  input  wire logic [W-1:0] d_in,    // Asynchronous pins
  output logic      [W-1:0] q_out    // Synchronised copy
);

  logic [W-1:0] meta;

  // No reset: settles within two cycles of any change
  always_ff @(posedge clk_in) begin
    meta  <= d_in;
    q_out <= meta;
  end

endmodule // pin_sync

`default_nettype wire

// [shared/pci_lock_params.svh]
`ifndef PCI_LOCK_PARAMS_SVH
`define PCI_LOCK_PARAMS_SVH

// Bus command codes as seen on the command/byte-enable pins
`define CMD_IACK        4'h0
`define CMD_SPECIAL     4'h1
`define CMD_MEM_RD      4'h6
`define CMD_MEM_WR      4'h7
`define CMD_MEM_RD_MULT 4'hC
`define CMD_MEM_RD_LINE 4'hE
`define CMD_MEM_WR_INV  4'hF

// Locked line is 32 bytes: address bits 31..5 name it
`define LINE_LSB        5
`define LINE_W          27
`define ADDR_STEP       32'h0000_0004

// Width of the synchronised pin vector
`define SYNC_W          44

// Reset values
`define RST_ADDR        32'h0000_0000
`define RST_LINE        27'h000_0000

`endif

// [shared/pci_lock_pkg.sv]
package pci_lock_pkg;

  // Lock tracking states, one-hot
  typedef enum logic [5:0] {
    LK_FREE  = 6'b000001,
    LK_REQ   = 6'b000010,
    LK_DRAIN = 6'b000100,
    LK_SNOOP = 6'b001000,
    LK_FIRST = 6'b010000,
    LK_HELD  = 6'b100000
  } lock_state_e;

  typedef logic [26:0] line_t;

endpackage

// [shared/pci_sample_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Sampled bus view shared by the lock logic and the parity unit
interface pci_sample_if;
  logic        pedge;     // Bus clock rising edge seen
  logic [31:0] ad;        // Sampled AD lines
  logic [3:0]  cbe;       // Sampled command/byte enables
  logic        par;       // Sampled parity pin
  logic        chk_addr;  // Check address parity now
  logic        chk_data;  // Check data parity now
  logic        special;   // Current cycle is a special cycle
  logic        resp_en;   // Parity error response enable
  logic        drv_oe;    // We drove AD in the ended clock
  logic [31:0] drv_ad;    // Data we drove
  logic        addr_err;  // Address parity error pulse
  logic        data_err;  // Data parity error pulse

  modport tgt (output pedge, ad, cbe, par, chk_addr, chk_data, special,
               resp_en, drv_oe, drv_ad,
               input addr_err, data_err);
  modport chk (input pedge, ad, cbe, par, chk_addr, chk_data, special,
               resp_en, drv_oe, drv_ad,
               output addr_err, data_err);
endinterface

`default_nettype wire

// [sim/pci_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Other initiator and its target; clock runs only inside its cycles
module pci_bus_model (
  input  wire logic  hold_trdy_in, // Target stall
  output logic       pci_clk_out,  // Bus clock
  output logic       frame_n_out,  // Frame, low
  output logic       irdy_n_out,   // Initiator ready
  output logic       trdy_n_out,   // Target ready
  output logic       lock_n_out,   // Lock, low
  output logic       par_out,      // Late parity
  output logic [3:0] cbe_n_out,    // Command/enables
  output logic [31:0] ad_out       // Address/data
);
  logic [35:0] last; // Phase covered by next parity

  initial begin
    {pci_clk_out, par_out, last} = '0;
    {frame_n_out, irdy_n_out, trdy_n_out, lock_n_out} = 4'hF;
    cbe_n_out = 4'hF;
    ad_out = 32'hFFFF_FFFF;
  end

  // One bus clock; parity trails its phase by one clock
  task automatic cyc(input logic bad);
    par_out = ^last ^ bad;
    last = {ad_out, cbe_n_out};
    #40 pci_clk_out = 1'h1;
    #40 pci_clk_out = 0;
  endtask

  // Address, wait state, n transfers, then three idle clocks
  task automatic txn(input logic [3:0] cmd, input logic [31:0] a,
                     input logic la, ld, lk, input int n,
                     input logic pa, pd);
    int i;
    int k;
    logic pb;
    i = 0;
    k = 0;
    pb = 0;
    frame_n_out = 0;
    cbe_n_out = cmd;
    ad_out = a;
    lock_n_out = ~la;
    cyc(1'h0);
    lock_n_out = ~ld;
    irdy_n_out = 0;
    cbe_n_out = 4'h0;
    frame_n_out = (n == 0);
    cyc(pa);
    while (i < n && k < 64) begin
      trdy_n_out = hold_trdy_in;
      frame_n_out = (i == n - 1) & ~hold_trdy_in;
      ad_out = a + i * 4;
      cyc(pb);
      pb = pd & (i == 0) & ~trdy_n_out;
      if (!trdy_n_out) i++;
      k++;
    end
    {frame_n_out, irdy_n_out, trdy_n_out} = 3'h7;
    lock_n_out = ~lk;
    ad_out = ~ad_out;
    cbe_n_out = ~cbe_n_out;
    cyc(pb);
    cyc(1'h0);
    cyc(1'h0);
  endtask

  // Drop lock with frame and irdy idle
  task automatic rel;
    lock_n_out = 1'h1;
    cyc(1'h0);
    cyc(1'h0);
  endtask
endmodule // pci_bus_model

`default_nettype wire

// [sim/pci_lock_target_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module pci_lock_target_sva
  import pci_lock_pkg::*;
(
  input wire logic        clk_in,              // Clock
  input wire logic        sys_rst_in,          // Reset
  input wire logic        wr_snoop_pending_in, // Older writes
  input wire logic        snoop_ack_in,        // Snoop done
  input wire logic        snoop_disable_in,    // No-snoop
  input wire logic        core_req_in,         // Core request
  input wire logic [31:0] core_addr_in,        // Core address
  input wire logic        parity_resp_en_in,   // Parity response
  input wire logic        dpe_clear_in,        // Status clear
  input wire logic        claim_out,           // Claimed
  input wire logic        retry_out,           // Retried
  input wire logic        snoop_req_out,       // Snoop request
  input wire logic        locked_out,          // Locked
  input wire line_t       lock_line_out,       // Locked line
  input wire logic        core_retry_out,      // Core retry
  input wire logic        perr_oe_out,         // Parity error on
  input wire logic        serr_oe_out,         // System error on
  input wire logic        dpe_status_out,      // Sticky status
  input wire logic        host_mode_out,       // Host mode
  input wire logic        config_error_out     // Bad straps
);
  // One domain; reset masks everything
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_retry_claim; retry_out |-> !claim_out; endproperty
  a_retry_claim: assert property (p_retry_claim)
    else $error("retry and claim together");
  property p_retry_lock; $rose(retry_out) |-> locked_out; endproperty
  a_retry_lock: assert property (p_retry_lock)
    else $error("retry while not locked");
  property p_drain; $rose(snoop_req_out) |-> !$past(wr_snoop_pending_in);
  endproperty
  a_drain: assert property (p_drain)
    else $error("lock snoop before older writes drained");
  property p_snp_hold; snoop_req_out && !snoop_ack_in |=> snoop_req_out;
  endproperty
  a_snp_hold: assert property (p_snp_hold)
    else $error("snoop request dropped early");
  // Core hazard: a hit on the held line must be bounced
  property p_core_hit;
    core_req_in && locked_out && core_addr_in[31:5] == lock_line_out
      |=> core_retry_out;
  endproperty
  a_core_hit: assert property (p_core_hit)
    else $error("core hit on locked line not retried");
  property p_core_miss;
    core_retry_out |-> $past(core_req_in) && $past(locked_out);
  endproperty
  a_core_miss: assert property (p_core_miss)
    else $error("core retried with no lock");
  property p_free_line; !locked_out |-> lock_line_out == 27'h0000000;
  endproperty
  a_free_line: assert property (p_free_line)
    else $error("line kept while free");
  property p_nosnoop; $rose(locked_out) |-> !snoop_disable_in; endproperty
  a_nosnoop: assert property (p_nosnoop)
    else $error("lock taken with snoop disabled");
  property p_pe_gate;
    $rose(perr_oe_out) || $rose(serr_oe_out)
      |-> parity_resp_en_in ##1 dpe_status_out;
  endproperty
  a_pe_gate: assert property (p_pe_gate)
    else $error("error pin without response enable");
  property p_dpe_keep; dpe_status_out && !dpe_clear_in |=> dpe_status_out;
  endproperty
  a_dpe_keep: assert property (p_dpe_keep)
    else $error("parity status lost");
  property p_cfg; config_error_out |-> !host_mode_out; endproperty
  a_cfg: assert property (p_cfg)
    else $error("config error in host mode");

  c_lock: cover property ($rose(locked_out));
  c_retry: cover property ($rose(retry_out));
  c_core: cover property ($rose(core_retry_out));
  c_serr: cover property ($rose(serr_oe_out));
endmodule // pci_lock_target_sva

bind pci_lock_target pci_lock_target_sva chk_u (.*);

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pci_lock_params.svh"

module testbench;
  logic        clk_in = 1'h0, sys_rst_in = 1'h1;
  wire logic   pci_clk_in, frame_n_in, irdy_n_in, trdy_n_in, lock_n_in;
  wire logic   par_in;
  wire logic [3:0]  cbe_n_in;
  wire logic [31:0] ad_in;
  logic        host_agent_select_strap_in = 1'h1, addr_map_b_strap_in = 1'h1;
  logic        mem_space_en_in = 1'h1, inbound_xlate_en_in = 1'h0;
  logic        snoop_disable_in = 1'h0, parity_resp_en_in = 1'h1;
  logic        dpe_clear_in = 1'h0, wr_snoop_pending_in = 1'h0;
  logic        snoop_ack_in = 1'h0, core_req_in = 1'h0;
  logic        rd_data_oe_in = 1'h1;
  logic [31:0] mem_base_in = 32'h0, mem_mask_in = 32'hF000_0000;
  logic [31:0] core_addr_in = 32'h0, rd_data_in = 32'h0123_4567;
  logic        claim_out, retry_out, hold_trdy_out, snoop_req_out;
  logic        locked_out, core_retry_out, par_out, par_oe_out;
  logic        perr_n_out, perr_oe_out, serr_n_out, serr_oe_out;
  logic        dpe_status_out, host_mode_out, config_error_out;
  logic [31:0] snoop_addr_out;
  logic [26:0] lock_line_out;
  logic        s_claim, s_retry, s_perr, s_serr;
  int          n_tests = 0, miscompares = 0;

  pci_lock_target dut_u (.*);
  pci_bus_model bus_u (.hold_trdy_in(hold_trdy_out), .pci_clk_out(pci_clk_in),
    .frame_n_out(frame_n_in), .irdy_n_out(irdy_n_in), .trdy_n_out(trdy_n_in),
    .lock_n_out(lock_n_in), .par_out(par_in), .cbe_n_out(cbe_n_in),
    .ad_out(ad_in));

  // Clock, sticky response capture, prompt snoop responder
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    s_claim |= claim_out;
    s_retry |= retry_out;
    s_perr |= ~perr_n_out;
    s_serr |= ~serr_n_out;
  end
  always @(negedge clk_in) snoop_ack_in <= snoop_req_out;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr;
    {s_claim, s_retry, s_perr, s_serr} = 4'h0;
  endtask
  // Straps are taken as reset lets go
  task automatic rst_run;
    sys_rst_in = 1'h1;
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'h0;
    repeat (4) @(negedge clk_in);
  endtask

  // Lock request stalls behind older write snoops
  task automatic t_lock;
    wr_snoop_pending_in = 1'h1;
    fork
      bus_u.txn(`CMD_MEM_RD, 32'h0000_1040, 0, 1, 1, 2, 0, 0);
      begin
        repeat (100) @(negedge clk_in);
        chk(snoop_req_out, 1'h0);
        wr_snoop_pending_in = 1'h0;
      end
    join
    chk(snoop_addr_out, 32'h0000_1040);
    chk(locked_out, 1'h1);
    chk(lock_line_out, 27'h82);
    clr;
    bus_u.txn(`CMD_MEM_RD, 32'h0000_2000, 1, 1, 1, 0, 0, 0);
    chk(s_retry, 1'h1);
    chk(s_claim, 1'h0);
    chk(locked_out, 1'h1);
  endtask

  // Core side: same line bounced, next line passes
  task automatic t_core;
    core_req_in = 1'h1;
    core_addr_in = 32'h0000_105C;
    repeat (2) @(negedge clk_in);
    chk(core_retry_out, 1'h1);
    core_addr_in = 32'h0000_1060;
    repeat (2) @(negedge clk_in);
    chk(core_retry_out, 1'h0);
    core_req_in = 1'h0;
  endtask

  // Owner continues on a new line, then releases
  task automatic t_cont;
    clr;
    bus_u.txn(`CMD_MEM_WR, 32'h0000_3000, 0, 1, 1, 1, 0, 0);
    chk(s_claim, 1'h1);
    chk(s_retry, 1'h0);
    chk(lock_line_out, 27'h180);
    bus_u.rel;
    repeat (4) @(negedge clk_in);
    chk(locked_out, 1'h0);
    chk(lock_line_out, 27'h0);
    snoop_disable_in = 1'h1;
    bus_u.txn(`CMD_MEM_RD, 32'h0000_4000, 0, 1, 1, 1, 0, 0);
    chk(locked_out, 1'h0);
    bus_u.rel;
    snoop_disable_in = 1'h0;
  endtask

  // Cases: cmd, bad addr, bad data, response on, want perr, want serr
  task automatic t_par;
    logic [8:0] tab [4];
    logic [8:0] e;
    tab = '{9'h0F5, 9'h0EE, 9'h02D, 9'h0E8};
    for (int i = 0; i < 4; i++) begin
      e = tab[i];
      parity_resp_en_in = e[2];
      dpe_clear_in = 1'h1;
      @(negedge clk_in);
      dpe_clear_in = 1'h0;
      clr;
      bus_u.txn(e[8:5], 32'h0000_5000, 0, 0, 0, 1, e[4], e[3]);
      chk(dpe_status_out, 1'h1);
      chk(s_perr, e[1]);
      chk(s_serr, e[0]);
    end
    chk(par_out ^ (^{rd_data_in, cbe_n_in}), 1'h0);
    chk(par_oe_out, 1'h1);
  endtask

  // Agent mode: map A flagged, memory ignored until translation on
  task automatic t_mode;
    host_agent_select_strap_in = 1'h0;
    addr_map_b_strap_in = 1'h0;
    rst_run;
    chk(host_mode_out, 1'h0);
    chk(config_error_out, 1'h1);
    addr_map_b_strap_in = 1'h1;
    rst_run;
    chk(config_error_out, 1'h0);
    for (int i = 0; i < 2; i++) begin
      inbound_xlate_en_in = i[0];
      clr;
      bus_u.txn(`CMD_MEM_WR, 32'h0000_6000, 0, 0, 0, 1, 0, 0);
      chk(s_claim, i[0]);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_run;
    chk(host_mode_out, 1'h1);
    t_lock;
    t_core;
    t_cont;
    t_par;
    t_mode;
    close_out;
  end

  // Watchdog well past the expected run
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule // testbench

`default_nettype wire
